// file: hdl/sicm_sync.sv
// Two-stage synchroniser for oscillator status pins
`timescale 1ns/1ps
`default_nettype none

module sicm_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Asynchronous in, synchronous out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sicm_sync_state_t;

  sicm_sync_state_t s;
  sicm_sync_state_t next_s;

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("sicm_sync width must be at least one");
    end
  endgenerate

  // ==========================================================================
  // Stage one is read only by stage two
  always_comb begin
    next_s.stage1 = async_in;
    next_s.stage2 = s.stage1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sync_out = s.stage2;

endmodule

`default_nettype wire

// file: hdl/sicm_top.sv
// Secondary-oscillator idle clock control with APB register access
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Idle: CPU clock off, peripherals on secondary
// - Switch to secondary: primary off, flags updated
// - Sleep ignored when secondary oscillator disabled
// - Peripheral clocks wait for secondary oscillator
// - Wake: fixed delay, then CPU on secondary
// - Stay secondary run until primary ready
// - Primary ready: switch back automatically
// - Switchback: running flag clear, startup set
// - Wake leaves idle bit and select alone
// - Secondary oscillator keeps running after wake
module sicm_top #(
  parameter int WAKE_CYCLES = sicm_pkg::WAKE_CYCLES
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Core events
  input  wire logic        sleep_req,
  input  wire logic        wake_req,
  // Oscillator status pins
  input  wire logic        primary_ready,
  input  wire logic        secondary_running,
  // Clock control
  output logic             cpu_clk_en,
  output logic             periph_clk_en,
  output logic             sys_clk_sel,
  output logic             primary_osc_en,
  output logic             secondary_osc_en,
  output logic [2:0]       mode
);

  localparam int CNT_W = 8;

  generate
    if (WAKE_CYCLES < 1 || WAKE_CYCLES > 255) begin : g_bad_wake
      $error("sicm_top WAKE_CYCLES must lie in 1..255");
    end
  endgenerate

  typedef struct packed {
    sicm_pkg::sicm_mode_t    state;
    logic [CNT_W-1:0]        count;
    logic [7:0]              osc_ctl;
    logic [7:0]              tmr_ctl;
    logic                    startup_done;
    logic                    sec_clk_running;
    sicm_pkg::sicm_clk_t     clk;
    sicm_pkg::sicm_apb_rsp_t rsp;
  } sicm_state_t;

  sicm_state_t s;
  sicm_state_t next_s;

  logic [1:0] pins_sync;
  logic       pri_ready_s;
  logic       sec_running_s;

  // ==========================================================================
  // Pin synchronisers
  sicm_sync #(
    .WIDTH (2)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({primary_ready, secondary_running}),
    .sync_out (pins_sync)
  );

  assign pri_ready_s   = pins_sync[1];
  assign sec_running_s = pins_sync[0];

  // ==========================================================================
  // Decode
  logic       apb_access;
  logic       apb_commit;
  logic       hit_osc;
  logic       hit_tmr;
  logic       idle_enable_bit;
  logic [1:0] clock_select_field;
  logic       sec_osc_enable;
  logic       entry_ok;

  assign apb_access = psel && penable && !s.rsp.pready;
  assign apb_commit = psel && penable && s.rsp.pready;
  assign hit_osc = (paddr == sicm_pkg::ADDR_OSCILLATOR_CONTROL);
  assign hit_tmr = (paddr == sicm_pkg::ADDR_TIMER_ONE_CONTROL);
  assign idle_enable_bit = s.osc_ctl[sicm_pkg::OSC_IDLE_ENABLE_BIT];
  assign clock_select_field = s.osc_ctl[sicm_pkg::OSC_SELECT_LSB +: 2];
  assign sec_osc_enable = s.tmr_ctl[sicm_pkg::TMR_OSC_ENABLE_BIT];
  // Entry needs idle bit, select code and enabled oscillator
  assign entry_ok = idle_enable_bit && sec_osc_enable &&
                    (clock_select_field ==
                     sicm_pkg::SEL_SECONDARY);

  // ==========================================================================
  // Next state
  always_comb begin
    next_s = s;

    // APB: answer in the access cycle's following edge
    next_s.rsp.pready = 1'b0;
    next_s.rsp.pslverr = 1'b0;
    if (apb_access) begin
      next_s.rsp.pready = 1'b1;
      next_s.rsp.pslverr = !(hit_osc || hit_tmr);
      next_s.rsp.prdata = 32'h0000_0000;
      if (hit_osc) begin
        next_s.rsp.prdata[7:0] = s.osc_ctl;
        next_s.rsp.prdata[sicm_pkg::OSC_STARTUP_DONE_BIT] = s.startup_done;
      end else if (hit_tmr) begin
        next_s.rsp.prdata[7:0] = s.tmr_ctl;
        next_s.rsp.prdata[sicm_pkg::TMR_RUNNING_BIT] = s.sec_clk_running;
      end
    end
    // Write lands on the edge that completes the transfer
    if (apb_commit && pwrite) begin
      if (hit_osc) begin
        next_s.osc_ctl = pwdata[7:0] & sicm_pkg::OSC_WRITE_MASK;
      end else if (hit_tmr) begin
        next_s.tmr_ctl = pwdata[7:0] & sicm_pkg::TMR_WRITE_MASK;
      end
    end

    // Mode sequencer; wake touches no control register
    case (s.state)
      sicm_pkg::ST_RUN_PRIMARY: begin
        // Sleep without the enabled oscillator is dropped
        if (sleep_req && entry_ok) begin
          next_s.state = sicm_pkg::ST_TO_SECONDARY;
          next_s.clk.primary_osc_en = 1'b0;
          next_s.startup_done = 1'b0;
          next_s.sec_clk_running = 1'b1;
        end
      end
      sicm_pkg::ST_TO_SECONDARY: begin
        if (sec_running_s) begin
          next_s.state = sicm_pkg::ST_SECONDARY_IDLE;
        end else begin
          next_s.state = sicm_pkg::ST_WAIT_SECONDARY;
        end
      end
      sicm_pkg::ST_WAIT_SECONDARY: begin
        // Unstable early oscillation is not filtered here
        if (sec_running_s) begin
          next_s.state = sicm_pkg::ST_SECONDARY_IDLE;
        end
      end
      sicm_pkg::ST_SECONDARY_IDLE: begin
        if (wake_req) begin
          next_s.state = sicm_pkg::ST_WAKE_DELAY;
          next_s.count = CNT_W'(WAKE_CYCLES - 1);
          next_s.clk.primary_osc_en = 1'b1;
        end
      end
      sicm_pkg::ST_WAKE_DELAY: begin
        if (s.count == '0) begin
          next_s.state = sicm_pkg::ST_SECONDARY_RUN;
        end else begin
          next_s.count = s.count - 1'b1;
        end
      end
      sicm_pkg::ST_SECONDARY_RUN: begin
        // Primary ready only counts once the CPU is running
        if (pri_ready_s) begin
          next_s.state = sicm_pkg::ST_TO_PRIMARY;
        end
      end
      sicm_pkg::ST_TO_PRIMARY: begin
        next_s.state = sicm_pkg::ST_RUN_PRIMARY;
        next_s.sec_clk_running = 1'b0;
        next_s.startup_done = 1'b1;
      end
      default: begin
        next_s.state = sicm_pkg::ST_RUN_PRIMARY;
      end
    endcase

    // Gate enables follow the next mode; select changes only with both off
    case (next_s.state)
      sicm_pkg::ST_RUN_PRIMARY: begin
        next_s.clk.cpu_clk_en = 1'b1;
        next_s.clk.periph_clk_en = 1'b1;
        next_s.clk.sys_clk_sel = 1'b0;
      end
      sicm_pkg::ST_TO_SECONDARY, sicm_pkg::ST_WAIT_SECONDARY: begin
        next_s.clk.cpu_clk_en = 1'b0;
        next_s.clk.periph_clk_en = 1'b0;
        next_s.clk.sys_clk_sel = 1'b1;
      end
      sicm_pkg::ST_SECONDARY_IDLE, sicm_pkg::ST_WAKE_DELAY: begin
        next_s.clk.cpu_clk_en = 1'b0;
        next_s.clk.periph_clk_en = 1'b1;
        next_s.clk.sys_clk_sel = 1'b1;
      end
      sicm_pkg::ST_SECONDARY_RUN: begin
        next_s.clk.cpu_clk_en = 1'b1;
        next_s.clk.periph_clk_en = 1'b1;
        next_s.clk.sys_clk_sel = 1'b1;
      end
      sicm_pkg::ST_TO_PRIMARY: begin
        next_s.clk.cpu_clk_en = 1'b0;
        next_s.clk.periph_clk_en = 1'b0;
        next_s.clk.sys_clk_sel = 1'b0;
      end
      default: begin
        next_s.clk.cpu_clk_en = 1'b0;
        next_s.clk.periph_clk_en = 1'b0;
        next_s.clk.sys_clk_sel = 1'b0;
      end
    endcase

    // Oscillator enable is software's alone, never dropped by wake
    next_s.clk.secondary_osc_en =
      next_s.tmr_ctl[sicm_pkg::TMR_OSC_ENABLE_BIT];
  end

  // ==========================================================================
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s.state <= sicm_pkg::ST_RUN_PRIMARY;
      s.count <= '0;
      s.osc_ctl <= sicm_pkg::OSC_RESET;
      s.tmr_ctl <= sicm_pkg::TMR_RESET;
      s.startup_done <= 1'b1;
      s.sec_clk_running <= 1'b0;
      s.clk <= '{cpu_clk_en: 1'b1, periph_clk_en: 1'b1, sys_clk_sel: 1'b0,
                 primary_osc_en: 1'b1, secondary_osc_en: 1'b0};
      s.rsp <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.rsp.prdata;
  assign pready = s.rsp.pready;
  assign pslverr = s.rsp.pslverr;
  assign cpu_clk_en = s.clk.cpu_clk_en;
  assign periph_clk_en = s.clk.periph_clk_en;
  assign sys_clk_sel = s.clk.sys_clk_sel;
  assign primary_osc_en = s.clk.primary_osc_en;
  assign secondary_osc_en = s.clk.secondary_osc_en;
  assign mode = s.state;

  // ==========================================================================
  // Assertions
  localparam int WAKE_BOUND = WAKE_CYCLES + 1;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_idle_gating: assert property (
    (s.state == sicm_pkg::ST_SECONDARY_IDLE) |->
      (!cpu_clk_en && periph_clk_en && sys_clk_sel))
    else $error("idle mode gating wrong");

  a_entry_flags: assert property (
    $rose(s.sec_clk_running) |->
      (!primary_osc_en && !s.startup_done && !cpu_clk_en))
    else $error("entry flags or primary oscillator wrong");

  a_sleep_ignored: assert property (
    (s.state == sicm_pkg::ST_RUN_PRIMARY && sleep_req && !sec_osc_enable)
      |=> (s.state == sicm_pkg::ST_RUN_PRIMARY && cpu_clk_en))
    else $error("sleep taken with oscillator disabled");

  a_periph_hold: assert property (
    (s.state == sicm_pkg::ST_WAIT_SECONDARY && !sec_running_s)
      |=> !periph_clk_en)
    else $error("peripheral clock before oscillator runs");

  a_wake_delay: assert property (
    (s.state == sicm_pkg::ST_SECONDARY_IDLE && wake_req) |=>
      (!cpu_clk_en && periph_clk_en) ##[1:WAKE_BOUND]
      (cpu_clk_en && sys_clk_sel))
    else $error("CPU not resumed on secondary after delay");

  a_stay_run: assert property (
    (s.state == sicm_pkg::ST_SECONDARY_RUN && !pri_ready_s) |=>
      (s.state == sicm_pkg::ST_SECONDARY_RUN && sys_clk_sel))
    else $error("left secondary run early");

  a_switch_back: assert property (
    (s.state == sicm_pkg::ST_SECONDARY_RUN && pri_ready_s) |=>
      (!sys_clk_sel && !cpu_clk_en) ##1 (cpu_clk_en && !sys_clk_sel))
    else $error("switchback to primary missing");

  a_back_flags: assert property (
    $fell(s.sec_clk_running) |-> (s.startup_done && !sys_clk_sel))
    else $error("switchback flags wrong");

  a_run_primary: assert property (
    (s.state == sicm_pkg::ST_RUN_PRIMARY) |->
      (!sys_clk_sel && primary_osc_en && cpu_clk_en))
    else $error("run mode not on primary clock");

  a_entry_gate: assert property (
    (s.state == sicm_pkg::ST_RUN_PRIMARY && sleep_req && !entry_ok)
      |=> (s.state == sicm_pkg::ST_RUN_PRIMARY))
    else $error("sleep taken without idle bit or select code");

  a_wake_cfg: assert property (
    (s.state == sicm_pkg::ST_SECONDARY_IDLE && wake_req && !apb_commit)
      |=> ($stable(s.osc_ctl) && $stable(s.tmr_ctl)))
    else $error("wake changed control bits");

  a_sec_kept: assert property (
    (s.state == sicm_pkg::ST_TO_PRIMARY && sec_osc_enable && !apb_commit)
      |=> secondary_osc_en)
    else $error("secondary oscillator dropped");

  a_dead_cycle: assert property (
    $changed(sys_clk_sel) |-> (!cpu_clk_en && !periph_clk_en))
    else $error("clock select changed while gated on");

  c_enter_idle: cover property (
    (s.state == sicm_pkg::ST_TO_SECONDARY) ##1
    (s.state == sicm_pkg::ST_SECONDARY_IDLE));
  c_wait_osc: cover property (s.state == sicm_pkg::ST_WAIT_SECONDARY);
  c_full_return: cover property (
    (s.state == sicm_pkg::ST_TO_PRIMARY) ##1
    (s.state == sicm_pkg::ST_RUN_PRIMARY));
  c_ignored: cover property (
    s.state == sicm_pkg::ST_RUN_PRIMARY && sleep_req && !sec_osc_enable);

endmodule

`default_nettype wire

// file: pkg/sicm_pkg.sv
// Package: register map, field layout, timing and types of the idle clock block
package sicm_pkg;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [11:0] IDX_TIMER_ONE_CONTROL = 12'hfcd;
  localparam logic [11:0] IDX_OSCILLATOR_CONTROL = 12'hfd3;
  localparam logic [15:0] ADDR_TIMER_ONE_CONTROL =
    {2'h0, IDX_TIMER_ONE_CONTROL, 2'h0};
  localparam logic [15:0] ADDR_OSCILLATOR_CONTROL =
    {2'h0, IDX_OSCILLATOR_CONTROL, 2'h0};

  // ==========================================================================
  // Field positions
  localparam int OSC_IDLE_ENABLE_BIT = 7;
  localparam int OSC_STARTUP_DONE_BIT = 3;
  localparam int OSC_SELECT_LSB = 0;
  localparam int TMR_RUNNING_BIT = 6;
  localparam int TMR_OSC_ENABLE_BIT = 3;

  // Bits that software may write; the rest are status or read as zero
  localparam logic [7:0] OSC_WRITE_MASK = 8'hf3;
  localparam logic [7:0] TMR_WRITE_MASK = 8'hbf;

  // Select code naming the secondary oscillator; an implementation constant
  localparam logic [1:0] SEL_SECONDARY = 2'h1;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] OSC_RESET = 8'h00;
  localparam logic [7:0] TMR_RESET = 8'h00;

  // ==========================================================================
  // Timing
  localparam int PCLK_PERIOD_NS = 50;
  localparam int WAKE_DELAY_NS = 1000;
  localparam int WAKE_CYCLES =
    (WAKE_DELAY_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    ST_RUN_PRIMARY = 3'b000,
    ST_TO_SECONDARY = 3'b001,
    ST_WAIT_SECONDARY = 3'b010,
    ST_SECONDARY_IDLE = 3'b011,
    ST_WAKE_DELAY = 3'b100,
    ST_SECONDARY_RUN = 3'b101,
    ST_TO_PRIMARY = 3'b110
  } sicm_mode_t;

  typedef struct packed {
    logic        cpu_clk_en;
    logic        periph_clk_en;
    logic        sys_clk_sel;
    logic        primary_osc_en;
    logic        secondary_osc_en;
  } sicm_clk_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } sicm_apb_rsp_t;

endpackage

// file: test/sicm_osc_model.sv
// Oscillator sources model: status pins follow enables after start-up delays
`timescale 1ns/1ps
`default_nettype none

module sicm_osc_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Enables from the block
  input  wire logic       primary_osc_en,
  input  wire logic       secondary_osc_en,
  // Start-up delays in cycles, set by the bench
  input  wire logic [7:0] pri_delay,
  input  wire logic [7:0] sec_delay,
  // Status pins
  output logic            primary_ready,
  output logic            secondary_running
);
  int pri_cnt;
  int sec_cnt;

  // ==========================================================================
  // Start-up counters
  // An enable drop stops the pin at once; no warm restart is modelled
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pri_cnt <= 0;
      sec_cnt <= 0;
      primary_ready <= 1'b0;
      secondary_running <= 1'b0;
    end else begin
      pri_cnt <= primary_osc_en ? pri_cnt + 1 : 0;
      sec_cnt <= secondary_osc_en ? sec_cnt + 1 : 0;
      primary_ready <= primary_osc_en && pri_cnt >= pri_delay;
      secondary_running <= secondary_osc_en && sec_cnt >= sec_delay;
    end
  end
endmodule

`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench for the idle clock block
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  // ==========================================================================
  // Settings and signals
  localparam int          WK = 3;
  localparam logic [15:0] A_OSC = sicm_pkg::ADDR_OSCILLATOR_CONTROL;
  localparam logic [15:0] A_TMR = sicm_pkg::ADDR_TIMER_ONE_CONTROL;
  localparam logic [31:0] OSC_IDLE = 32'h80 | sicm_pkg::SEL_SECONDARY;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0;
  logic        sleep_req = 1'b0;
  logic        wake_req = 1'b0;
  logic [7:0]  pri_delay = 8'h10;
  logic [7:0]  sec_delay = 8'h01;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        primary_ready;
  logic        secondary_running;
  logic        cpu_clk_en;
  logic        periph_clk_en;
  logic        sys_clk_sel;
  logic        primary_osc_en;
  logic        secondary_osc_en;
  logic [2:0]  mode;
  int          err_total = 0;
  int          samples_checked = 0;
  int          osc_m = 0;
  int          tmr_m = 0;
  int          startup = 1;
  int          running = 0;
  int          n;
  logic [31:0] bad_sel [2];

  always #25 pclk = ~pclk;

  sicm_top #(.WAKE_CYCLES(WK)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleep_req(sleep_req),
    .wake_req(wake_req), .primary_ready(primary_ready),
    .secondary_running(secondary_running), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .sys_clk_sel(sys_clk_sel),
    .primary_osc_en(primary_osc_en), .secondary_osc_en(secondary_osc_en),
    .mode(mode));

  sicm_osc_model osc (
    .pclk(pclk), .presetn(presetn), .primary_osc_en(primary_osc_en),
    .secondary_osc_en(secondary_osc_en), .pri_delay(pri_delay),
    .sec_delay(sec_delay), .primary_ready(primary_ready),
    .secondary_running(secondary_running));

  // ==========================================================================
  // Compare and verdict
  task automatic chk(input string w, input logic [31:0] e,
                     input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", w, e, s);
    end
  endtask

  task automatic chk_clk(input sicm_pkg::sicm_clk_t e,
                         input sicm_pkg::sicm_clk_t s);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("unexpected clocks expected %b seen %b", e, s);
    end
  endtask

  task automatic give_verdict();
    if (err_total == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ==========================================================================
  // Expected gates per mode: cpu, periph, select, primary, secondary enable
  function automatic sicm_pkg::sicm_clk_t exp_clk(input logic [2:0] m);
    logic [3:0] t;
    case (m)
      3'h0: t = 4'b1101;
      3'h1: t = 4'b0010;
      3'h2: t = 4'b0010;
      3'h3: t = 4'b0110;
      3'h4: t = 4'b0111;
      3'h5: t = 4'b1111;
      3'h6: t = 4'b0001;
      default: t = 4'bxxxx;
    endcase
    return {t, tmr_m[3]};
  endfunction

  always @(negedge pclk) begin
    if (presetn) begin
      chk_clk(exp_clk(mode), {cpu_clk_en, periph_clk_en, sys_clk_sel,
              primary_osc_en, secondary_osc_en});
    end
  end

  // ==========================================================================
  // APB master and register model
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    chk("apb_wait", 32'h1, {31'h0, pready});
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    chk("write_err", 32'(a != A_OSC && a != A_TMR), {31'h0, e});
    if (a == A_OSC) osc_m = d[7:0] & sicm_pkg::OSC_WRITE_MASK;
    if (a == A_TMR) tmr_m = d[7:0] & sicm_pkg::TMR_WRITE_MASK;
  endtask

  task automatic rd(input logic [15:0] a);
    logic [31:0] r;
    logic        e;
    int          x;
    x = a == A_OSC ? osc_m | startup << 3 :
        a == A_TMR ? tmr_m | running << 6 : 0;
    apb(1'b0, a, 32'h0, r, e);
    chk("read_data", x, r);
    chk("read_err", 32'(a != A_OSC && a != A_TMR), {31'h0, e});
  endtask

  task automatic pulse_sleep();
    @(posedge pclk);
    sleep_req <= 1'b1;
    @(posedge pclk);
    sleep_req <= 1'b0;
    @(negedge pclk);
  endtask

  task automatic wait_mode(input logic [2:0] m);
    int k;
    k = 0;
    while (mode !== m && k < 300) begin
      @(negedge pclk);
      k++;
    end
    chk("mode_reached", m, mode);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    void'($urandom(32'h5b1d));
    bad_sel[0] = {24'h0, 6'h0, sicm_pkg::SEL_SECONDARY};
    bad_sel[1] = OSC_IDLE ^ 32'h3;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_OSC);
    rd(A_TMR);
    rd(16'h0000);
    wr(16'h0010, $urandom);
    repeat (3) begin
      wr(A_OSC, $urandom);
      wr(A_TMR, $urandom & 32'hfffffff7);
      rd(A_OSC);
      rd(A_TMR);
    end
    // Oscillator disabled: sleep must be dropped
    wr(A_OSC, OSC_IDLE);
    wr(A_TMR, 32'h0);
    pulse_sleep();
    chk("mode", 3'h0, mode);
    // Slow secondary start first, then an oscillator already running
    for (int c = 0; c < 2; c++) begin
      sec_delay <= c == 0 ? 8'(20 + $urandom % 10) : 8'h01;
      pri_delay <= 8'(WK + 6 + $urandom % 4);
      wr(A_TMR, 32'h08 | ($urandom & 32'hb7));
      rd(A_TMR);
      wr(A_OSC, OSC_IDLE | ($urandom & 32'h70));
      pulse_sleep();
      chk("mode", 3'h1, mode);
      startup = 0;
      running = 1;
      @(negedge pclk);
      chk("mode", c == 0 ? 3'h2 : 3'h3, mode);
      wait_mode(3'h3);
      chk("sec_running", 32'h1, {31'h0, secondary_running});
      pulse_sleep();
      chk("mode", 3'h3, mode);
      rd(A_OSC);
      rd(A_TMR);
      @(posedge pclk);
      wake_req <= 1'b1;
      @(posedge pclk);
      wake_req <= 1'b0;
      n = 0;
      @(negedge pclk);
      while (mode === 3'h4 && n < 300) begin
        n++;
        @(negedge pclk);
      end
      chk("wake_cycles", WK, n);
      chk("mode", 3'h5, mode);
      chk("pri_ready", 32'h0, {31'h0, primary_ready});
      wait_mode(3'h6);
      chk("pri_ready", 32'h1, {31'h0, primary_ready});
      @(negedge pclk);
      chk("mode", 3'h0, mode);
      startup = 1;
      running = 0;
      rd(A_OSC);
      rd(A_TMR);
    end
    // Idle bit clear or another select code: sleep dropped too
    foreach (bad_sel[i]) begin
      wr(A_OSC, bad_sel[i]);
      pulse_sleep();
      chk("mode", 3'h0, mode);
    end
    give_verdict();
  end

  // Whole run is well under a thousand cycles
  initial begin
    repeat (5000) @(posedge pclk);
    err_total++;
    give_verdict();
  end
endmodule

`default_nettype wire
